// ---- rtl/shlc_params.svh ----
// Constants for the step, homing and lash controller.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef SHLC_PARAMS_SVH
`define SHLC_PARAMS_SVH

// Step pulse timing at the driver input, nanoseconds.
`define SHLC_CLK_PERIOD_NS  100
`define SHLC_PULSE_HIGH_NS  1000
`define SHLC_PULSE_LOW_NS   1000
// Cycle counts, rounded up from the least times.
`define SHLC_HIGH_CYC \
  ((`SHLC_PULSE_HIGH_NS + `SHLC_CLK_PERIOD_NS - 1) / `SHLC_CLK_PERIOD_NS)
`define SHLC_LOW_CYC \
  ((`SHLC_PULSE_LOW_NS + `SHLC_CLK_PERIOD_NS - 1) / `SHLC_CLK_PERIOD_NS)
// Command codes.
`define SHLC_CMD_MOVE 2'h0
`define SHLC_CMD_SEEK 2'h1
`define SHLC_CMD_SETP 2'h2
`define SHLC_CMD_HOME 2'h3
// Reset value and lash width.
`define SHLC_POS_RST  32'h0000_0000
`define SHLC_LASH_W   8

`endif

// ---- rtl/shlc_pkg.sv ----
// State type used by the controller; the step pulse generator uses none.
// Assumes shlc_params.svh is compiled alongside.
package shlc_pkg;
  typedef enum logic [7:0] {
    SHLC_IDLE  = 8'h01,
    SHLC_LASH  = 8'h02,
    SHLC_RUN   = 8'h04,
    SHLC_H_APP = 8'h08,
    SHLC_H_BCK = 8'h10,
    SHLC_H_CLR = 8'h20,
    SHLC_DONE  = 8'h40,
    SHLC_H_ZER = 8'h80
  } shlc_state_t;
endpackage

// ---- rtl/shlc_pulse_gen.sv ----
// Step pulse generator: idle high, low phase then high phase per step.
// Assumes the sequencer only changes direction while this is idle.
`timescale 1ns/100ps
`include "shlc_params.svh"
module shlc_pulse_gen (
  input  wire logic   clk_i,    // System clock.
  input  wire logic   rst_n_i,  // Asynchronous reset, active low.
  shlc_step_if.gen    stp,      // Step request link.
  output logic        step_o    // Step pulse, rests high.
);
  logic [7:0] cnt_r;
  logic [1:0] ph_r;   // 0 idle, 1 low phase, 2 high recovery.

  // Low phase then high recovery; the line rests high so that
  // direction may change between pulses.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_r     <= 2'h0;
      cnt_r    <= 8'h00;
      step_o   <= 1'b1;
      stp.done <= 1'b0;
    end else begin
      stp.done <= 1'b0;
      case (ph_r)
        2'h0: if (stp.req) begin
          ph_r   <= 2'h1;
          cnt_r  <= 8'(`SHLC_LOW_CYC - 1);
          step_o <= 1'b0;
        end
        2'h1: if (cnt_r == 8'h00) begin
          ph_r   <= 2'h2;
          cnt_r  <= 8'(`SHLC_HIGH_CYC - 1);
          step_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
        default: if (cnt_r == 8'h00) begin
          ph_r     <= 2'h0;
          stp.done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      endcase
    end
  end

  assign stp.busy = (ph_r != 2'h0) | stp.done;
endmodule // shlc_pulse_gen

// ---- rtl/shlc_step_if.sv ----
// Link between the motion sequencer and the step pulse generator.
// Assumes both ends share clk_i.
`timescale 1ns/100ps
interface shlc_step_if;
  logic req;   // Request one step pulse.
  logic busy;  // Pulse generator is mid-pulse or in its done cycle.
  logic done;  // One cycle when a step completes.
  modport seq (output req, input busy, input done);
  modport gen (input req, output busy, output done);
endinterface

// ---- rtl/step_homing_lash_controller.sv ----
// Single-axis step/direction sequencer with homing and lash take-up.
// Assumes home switches arrive asynchronously, are normally open and
// active high when closed; commands come from same-clock logic.
// The readout trails the position counter by one clock.
`timescale 1ns/100ps
`include "shlc_params.svh"

////////////////////////////////////////////////////////////////////////
// What this block does
// - A seek runs the set way and distance but stops on a home change.
// - A set-position command loads the position and makes no motion.
// - Any closed home switch lights the shared home signal and indicator.
// - Direction changes only while the step line is held high.
// - The homing approach halts on switch closure or at maximum travel.
// - Back-off stops on opening, zeroes, steps clear and zeroes again.
// - Each reversal between commands inserts the set number of lash steps; the homing back-off reversal inserts none.
// - The lash value is an eight-bit step count up to 255.
// - Lash steps move the motor but are not counted in the position.
module step_homing_lash_controller #(
  parameter int NSW     = 3,   // Number of parallel home switches.
  parameter int POS_W   = 32,  // Position counter width.
  parameter int CLEAR_N = 1    // Extra clearing steps after back-off.
) (
  input  wire logic              clk_i,       // System clock 10 MHz.
  input  wire logic              rst_n_i,     // Async reset, active low.
  input  wire logic              cmd_vld_i,   // Command strobe.
  input  wire logic [1:0]        cmd_op_i,    // Command code.
  input  wire logic              cmd_dir_i,   // 1 forward, 0 reverse.
  input  wire logic [POS_W-1:0]  cmd_arg_i,   // Distance or position.
  input  wire logic [`SHLC_LASH_W-1:0] lash_i, // Lash step count.
  input  wire logic [NSW-1:0]    home_sw_i,   // Home switches, 1 closed.
  output logic                   step_o,      // Step pulse to driver.
  output logic                   dir_o,       // Direction to driver.
  output logic                   home_led_o,  // Any switch closed.
  output logic                   busy_o,      // Command in progress.
  output logic [POS_W-1:0]       position_readout_o // Axis position.
);
  shlc_step_if stp ();

  shlc_pkg::shlc_state_t st_r;
  shlc_pkg::shlc_state_t st_nxt;
  logic [NSW-1:0]          sw_m_r;
  logic [NSW-1:0]          sw_s_r;
  logic                    home_ref_r;
  logic [POS_W-1:0]        pos_r;
  logic [POS_W-1:0]        left_r;
  logic [`SHLC_LASH_W-1:0] lash_left_r;
  logic                    req_r;
  logic                    dir_seen_r;
  logic                    home_any;
  logic                    home_chg;
  logic                    rev;
  logic                    stepping;
  logic                    take;

  ////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser per switch input.
  // The first stage is read only by the second, never by logic.
  genvar g;
  generate
    for (g = 0; g < NSW; g++) begin : g_sync
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sw_m_r[g] <= 1'b0;
          sw_s_r[g] <= 1'b0;
        end else begin
          sw_m_r[g] <= home_sw_i[g];
          sw_s_r[g] <= sw_m_r[g];
        end
      end
    end
  endgenerate

  assign home_any = |sw_s_r;
  assign home_chg = home_any ^ home_ref_r;
  // Reversal against the direction last driven on dir_o, stepped or not.
  assign rev      = dir_seen_r & (cmd_dir_i != dir_o);
  assign take     = cmd_vld_i & (st_r == shlc_pkg::SHLC_IDLE);
  assign stepping = (st_r != shlc_pkg::SHLC_IDLE) &
                    (st_r != shlc_pkg::SHLC_DONE) &
                    (st_r != shlc_pkg::SHLC_H_ZER);
  assign stp.req  = req_r;

  ////////////////////////////////////////////////////////////////////
  // Next state. Every stop is taken between pulses, with the step
  // line high, so that a reversal that follows never meets a low step
  // line and the shaft never stops half way through a pulse.
  // A seek compares the synchronised home level with the level seen
  // at the take, so that either sense of change ends the move.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      shlc_pkg::SHLC_IDLE: begin
        if (take && cmd_op_i != `SHLC_CMD_SETP) begin
          if (rev && lash_i != '0)
            st_nxt = shlc_pkg::SHLC_LASH;
          else if (cmd_op_i == `SHLC_CMD_HOME)
            st_nxt = shlc_pkg::SHLC_H_APP;
          else
            st_nxt = shlc_pkg::SHLC_RUN;
        end
      end
      shlc_pkg::SHLC_LASH: begin
        if (stp.done && lash_left_r == 8'h01)
          st_nxt = (cmd_op_i == `SHLC_CMD_HOME) ? shlc_pkg::SHLC_H_APP
                                               : shlc_pkg::SHLC_RUN;
      end
      shlc_pkg::SHLC_RUN: begin
        if (left_r == '0 ||
            (cmd_op_i == `SHLC_CMD_SEEK && home_chg && !stp.busy))
          st_nxt = shlc_pkg::SHLC_DONE;
      end
      shlc_pkg::SHLC_H_APP: begin
        if (!stp.busy && (home_any || left_r == '0))
          st_nxt = home_any ? shlc_pkg::SHLC_H_BCK : shlc_pkg::SHLC_DONE;
      end
      shlc_pkg::SHLC_H_BCK: begin
        if (!stp.busy && !home_any)
          st_nxt = shlc_pkg::SHLC_H_ZER;
      end
      shlc_pkg::SHLC_H_ZER: st_nxt = shlc_pkg::SHLC_H_CLR;
      shlc_pkg::SHLC_H_CLR: begin
        if (!stp.busy && left_r == '0)
          st_nxt = shlc_pkg::SHLC_DONE;
      end
      default: st_nxt = shlc_pkg::SHLC_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // State, direction and step request.
  // A new request waits one idle cycle after each pulse ends.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r       <= shlc_pkg::SHLC_IDLE;
      dir_o      <= 1'b1;
      dir_seen_r <= 1'b0;
      req_r      <= 1'b0;
      home_ref_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      req_r <= stepping && (st_nxt == st_r) && !stp.busy && !req_r &&
               !(st_r == shlc_pkg::SHLC_RUN && left_r == '0);
      if (take && cmd_op_i != `SHLC_CMD_SETP) begin
        // direction only while step idles high
        dir_o      <= cmd_dir_i;
        dir_seen_r <= 1'b1;
        home_ref_r <= home_any;
      end else if (st_r == shlc_pkg::SHLC_H_APP &&
                   st_nxt == shlc_pkg::SHLC_H_BCK) begin
        // reversal made with the step line high
        dir_o <= ~dir_o;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Counters: distance left, lash left and position.
  // The zeroing after the clearing move lands one cycle after the
  // count of the final clearing step and overwrites its result.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_r      <= '0;
      lash_left_r <= '0;
      pos_r       <= POS_W'(`SHLC_POS_RST);
    end else begin
      if (take) begin
        if (cmd_op_i == `SHLC_CMD_SETP)
          pos_r <= cmd_arg_i;
        left_r      <= cmd_arg_i;
        lash_left_r <= lash_i;
      end else if (st_r == shlc_pkg::SHLC_H_ZER) begin
        pos_r  <= '0;
        left_r <= POS_W'(CLEAR_N);
      end else if (stp.done) begin
        if (st_r == shlc_pkg::SHLC_LASH) begin
          lash_left_r <= lash_left_r - 8'h01;
        end else begin
          pos_r <= dir_o ? pos_r + 1'b1 : pos_r - 1'b1;
          if (left_r != '0)
            left_r <= left_r - 1'b1;
        end
      end
      if (st_r == shlc_pkg::SHLC_H_CLR && st_nxt == shlc_pkg::SHLC_DONE)
        pos_r <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registered status outputs; the readout trails the counter by
  // one cycle because every output comes straight from a flop.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      home_led_o         <= 1'b0;
      busy_o             <= 1'b0;
      position_readout_o <= '0;
    end else begin
      home_led_o         <= home_any;
      busy_o             <= (st_nxt != shlc_pkg::SHLC_IDLE);
      position_readout_o <= pos_r;
    end
  end

  // Step pulse generator; it owns the step line and its timing.
  shlc_pulse_gen u_gen (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .stp     (stp),
    .step_o  (step_o)
  );
endmodule // step_homing_lash_controller

// ---- sim/shlc_checker.sv ----
// Port checker for the step, homing and lash controller.
// Assumes inputs change on the falling clock edge.
`timescale 1ns/100ps
`include "shlc_params.svh"
module shlc_checker #(
  parameter int NSW   = 3,  // Switch count.
  parameter int POS_W = 32  // Position width.
) (
  input wire logic             clk_i,              // Clock.
  input wire logic             rst_n_i,            // Reset, low.
  input wire logic             cmd_vld_i,          // Strobe.
  input wire logic [1:0]       cmd_op_i,           // Code.
  input wire logic             cmd_dir_i,          // Direction.
  input wire logic [POS_W-1:0] cmd_arg_i,          // Argument.
  input wire logic [7:0]       lash_i,             // Lash count.
  input wire logic [NSW-1:0]   home_sw_i,          // Switches.
  input wire logic             step_o,             // Step.
  input wire logic             dir_o,              // Direction.
  input wire logic             home_led_o,         // Indicator.
  input wire logic             busy_o,             // Busy.
  input wire logic [POS_W-1:0] position_readout_o  // Position.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Low phase of ten cycles, then the rising edge.
  sequence s_low;
    !step_o [*8] ##1 !step_o [*2] ##1 step_o;
  endsequence
  sequence s_high;
    step_o [*8] ##1 step_o [*2];
  endsequence
  a_dir_step_high: assert property (
    $changed(dir_o) |-> step_o && $past(step_o))
    else $error("direction changed with step low");
  a_led_any_sw: assert property (
    home_led_o == (|$past(home_sw_i, 3)))
    else $error("indicator not the OR of switches");
  a_setp_load: assert property (
    cmd_vld_i && !busy_o && cmd_op_i == `SHLC_CMD_SETP |->
    ##1 !busy_o ##1 position_readout_o == $past(cmd_arg_i, 2))
    else $error("preset not loaded");
  a_step_low: assert property ($fell(step_o) |-> s_low)
    else $error("step low phase wrong");
  a_step_high: assert property ($rose(step_o) |-> s_high)
    else $error("step high phase short");
  a_busy_take: assert property (
    cmd_vld_i && !busy_o && cmd_op_i != `SHLC_CMD_SETP |=> busy_o)
    else $error("command not taken");
  a_idle_still: assert property (!busy_o |-> step_o)
    else $error("step while idle");
  a_pos_unit: assert property (
    busy_o && $changed(position_readout_o) |-> position_readout_o == 0 ||
    position_readout_o ==
    $past(position_readout_o) + ($past(dir_o) ? 1 : -1))
    else $error("position moved by more than one");
endmodule // shlc_checker
bind step_homing_lash_controller shlc_checker #(.NSW(NSW), .POS_W(POS_W))
  u_chk (.*);

// ---- sim/shlc_motor_model.sv ----
// Behavioural shaft and home switch bank.
// Assumes a switch is closed whenever the shaft is below zero.
`timescale 1ns/100ps
module shlc_motor_model #(
  parameter int NSW = 3  // Switch count.
) (
  input  wire logic           rst_n_i,   // Reset, low.
  input  wire logic           step_i,    // Step pin.
  input  wire logic           dir_i,     // Direction pin.
  input  wire logic [1:0]     sel_i,     // Switch reached.
  output logic      [NSW-1:0] home_sw_o  // Switches, 1 closed.
);
  int pos = 0;  // Shaft position, lash steps included.
  always @(posedge step_i) begin
    pos = !rst_n_i ? 0 : pos + (dir_i ? 1 : -1);
  end
  assign home_sw_o = (pos < 0) ? NSW'(1) << sel_i : '0;
endmodule // shlc_motor_model

// ---- sim/step_homing_lash_controller_tb.sv ----
// Self-checking bench for the step, homing and lash controller.
// Assumes the motor model drives the switch bank.
`timescale 1ns/100ps
`include "shlc_params.svh"
module step_homing_lash_controller_tb;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cmd_vld_i = 1'b0;
  logic [1:0]  cmd_op_i = 2'h0;
  logic        cmd_dir_i = 1'b0;
  logic [31:0] cmd_arg_i = 32'h0000_0000;
  logic [7:0]  lash_i = 8'h00;
  logic [1:0]  sel = 2'h0;
  logic [2:0]  home_sw_i;
  logic        step_o;
  logic        dir_o;
  logic        home_led_o;
  logic        busy_o;
  logic [31:0] rd;
  int          num_errors = 0;
  int          samples_checked = 0;
  step_homing_lash_controller #(.NSW(3), .POS_W(32), .CLEAR_N(1)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_vld_i(cmd_vld_i),
    .cmd_op_i(cmd_op_i), .cmd_dir_i(cmd_dir_i), .cmd_arg_i(cmd_arg_i),
    .lash_i(lash_i), .home_sw_i(home_sw_i), .step_o(step_o),
    .dir_o(dir_o), .home_led_o(home_led_o), .busy_o(busy_o),
    .position_readout_o(rd));
  shlc_motor_model #(.NSW(3)) mp (.rst_n_i(rst_n_i), .step_i(step_o),
    .dir_i(dir_o), .sel_i(sel), .home_sw_o(home_sw_i));
  // Clock of 100 ns period.
  initial forever #50 clk_i = ~clk_i;
  task automatic check(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Issues one command and waits for the block to go idle.
  task automatic cmd(input logic [1:0] op, input logic d,
                     input logic [31:0] a, input logic [31:0] ep, es);
    int n = 0;
    @(negedge clk_i);
    cmd_op_i = op;
    cmd_dir_i = d;
    cmd_arg_i = a;
    cmd_vld_i = 1'b1;
    @(negedge clk_i);
    cmd_vld_i = 1'b0;
    @(negedge clk_i);
    while (busy_o !== 1'b0 && n < 20000) begin
      @(negedge clk_i);
      n++;
    end
    repeat (2) @(negedge clk_i);
    check("busy", 32'h0, busy_o);
    check("position", ep, rd);
    check("shaft", es, mp.pos);
  endtask
  task automatic t_move_lash();
    cmd(`SHLC_CMD_MOVE, 1'b1, 32'h3, 32'h3, 32'h3);
    lash_i = 8'hff;
    cmd(`SHLC_CMD_MOVE, 1'b0, 32'h2, 32'h1, -254);
    cmd(`SHLC_CMD_MOVE, 1'b1, 32'h1, 32'h2, 32'h2);
    cmd(`SHLC_CMD_MOVE, 1'b1, 32'h1, 32'h3, 32'h3);
    lash_i = 8'h00;
  endtask
  task automatic t_seek();
    cmd(`SHLC_CMD_SETP, 1'b0, 32'h10, 32'h10, 32'h3);
    sel = 2'h1;
    cmd(`SHLC_CMD_SEEK, 1'b0, 32'h64, 32'hc, -1);
    cmd(`SHLC_CMD_SEEK, 1'b1, 32'h64, 32'hd, 32'h0);
    cmd(`SHLC_CMD_SEEK, 1'b1, 32'h2, 32'hf, 32'h2);
  endtask
  task automatic t_home();
    sel = 2'h2;
    cmd(`SHLC_CMD_HOME, 1'b0, 32'h64, 32'h0, 32'h1);
    cmd(`SHLC_CMD_HOME, 1'b1, 32'h3, 32'h3, 32'h4);
    cmd(`SHLC_CMD_SEEK, 1'b0, 32'h64, -2, -1);
    check("indicator", 1'b1, home_led_o);
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence after a reset of 16 cycles.
  initial begin
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_move_lash();
    t_seek();
    t_home();
    conclude();
  end
  // Watchdog well beyond the expected run of some 12000 cycles.
  initial begin
    #5000000;
    num_errors++;
    conclude();
  end
endmodule // step_homing_lash_controller_tb
